//--- cs_clock_map.svh
// Register indices, field positions, reset values and timing figures of the clock select block
`ifndef CS_CLOCK_MAP_SVH
`define CS_CLOCK_MAP_SVH
`define CS_IDX_SRC     14'h1c00
`define CS_IDX_ST3     14'h1c01
`define CS_IDX_BOOT    14'h1c02
`define CS_IDX_STAT    14'h1c03
`define CS_IDX_SLEW    14'h1c16
`define CS_OFF_BIT     0
`define CS_GO_BIT      0
`define CS_REF_LSB     1
`define CS_REF_MSB     2
`define CS_BYP_BIT     3
`define CS_MULT_LSB    4
`define CS_MULT_MSB    15
`define CS_SRC_LSB     0
`define CS_SRC_MSB     1
`define CS_SLEW_RST    16'h0000
`define CS_MULT_RST    12'h001
`define CS_PLL_MAX_HZ  120000000
`define CS_OSC_HZ      32768
`define CS_REF0_HZ     11289600
`define CS_REF1_HZ     12000000
`define CS_REF2_HZ     12288000
`define CS_SPI_HZ      500000
`define CS_I2C_HZ      400000
`define CS_CEIL(a, b)  (((a) + (b) - 1) / (b))
`define CS_DBG_DIV     8'h04
`endif

//--- cs_clock_pkg.sv
// Types shared by the clock select block
package cs_clock_pkg;

  typedef enum logic [1:0] {
    CS_BOOT_WAIT = 2'h0,
    CS_BOOT_LOAD = 2'h1,
    CS_BOOT_DONE = 2'h3
  } cs_boot_t;

  typedef enum logic [1:0] {
    CS_SRC_SYSREF = 2'h0,
    CS_SRC_PLL    = 2'h1,
    CS_SRC_RTC    = 2'h2,
    CS_SRC_DIV    = 2'h3
  } cs_src_t;

  typedef struct packed {
    cs_src_t     src;
    logic        off;
    logic [1:0]  ref_sel;
    logic        bypass;
    logic [11:0] mult;
    logic [15:0] slew;
    logic [7:0]  spi_div;
    logic [7:0]  i2c_div;
  } cs_regs_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [29:0] addr;
  } cs_bus_t;

endpackage

//--- cs_clock_select.sv
// Clock source select, debug clock output control and their AHB-Lite registers
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cs_clock_map.svh"

////////////////////////////////////////////////////////////////////////////////
module cs_clock_select (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clock_select_strap,
  input  wire logic        osc_32k_clock,
  input  wire logic        external_reference_clock_input,
  input  wire logic        pll_output_clock,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             sys_ref_clock,
  output logic             rtc_clock,
  output logic             debug_clock_output_pin,
  output logic             debug_clock_output_oe,
  output logic      [15:0] debug_clock_slew,
  output logic             pll_bypass,
  output logic      [11:0] pll_mult,
  output logic      [7:0]  spi_clock_divider,
  output logic      [7:0]  i2c_clock_divider
);

  //////////////////////////////////////////////////////////////////////////////
  // Derived limits and boot divisors

  localparam logic [11:0] MAX_OSC  = 12'(`CS_PLL_MAX_HZ / `CS_OSC_HZ);
  localparam logic [11:0] MAX_REF0 = 12'(`CS_PLL_MAX_HZ / `CS_REF0_HZ);
  localparam logic [11:0] MAX_REF1 = 12'(`CS_PLL_MAX_HZ / `CS_REF1_HZ);
  localparam logic [11:0] MAX_REF2 = 12'(`CS_PLL_MAX_HZ / `CS_REF2_HZ);
  localparam logic [7:0]  SPI_OSC  = 8'(`CS_CEIL(`CS_OSC_HZ, `CS_SPI_HZ));
  localparam logic [7:0]  SPI_REF0 = 8'(`CS_CEIL(`CS_REF0_HZ, `CS_SPI_HZ));
  localparam logic [7:0]  SPI_REF1 = 8'(`CS_CEIL(`CS_REF1_HZ, `CS_SPI_HZ));
  localparam logic [7:0]  SPI_REF2 = 8'(`CS_CEIL(`CS_REF2_HZ, `CS_SPI_HZ));
  localparam logic [7:0]  I2C_OSC  = 8'(`CS_CEIL(`CS_OSC_HZ, `CS_I2C_HZ));
  localparam logic [7:0]  I2C_REF0 = 8'(`CS_CEIL(`CS_REF0_HZ, `CS_I2C_HZ));
  localparam logic [7:0]  I2C_REF1 = 8'(`CS_CEIL(`CS_REF1_HZ, `CS_I2C_HZ));
  localparam logic [7:0]  I2C_REF2 = 8'(`CS_CEIL(`CS_REF2_HZ, `CS_I2C_HZ));

  // Multiplier ceiling for the current reference; rounding down keeps PLL out in range
  function automatic logic [11:0] mult_max(input logic strap, input logic [1:0] sel);
    if (!strap)
      return MAX_OSC;
    unique case (sel)
      2'h0:    return MAX_REF0;
      2'h1:    return MAX_REF1;
      default: return MAX_REF2;
    endcase
  endfunction

  // Divisors round up so the serial clocks never exceed their target rates
  function automatic logic [15:0] boot_divs(input logic strap, input logic [1:0] sel);
    if (!strap)
      return {I2C_OSC, SPI_OSC};
    unique case (sel)
      2'h0:    return {I2C_REF0, SPI_REF0};
      2'h1:    return {I2C_REF1, SPI_REF1};
      default: return {I2C_REF2, SPI_REF2};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  cs_clock_pkg::cs_regs_t regs;
  cs_clock_pkg::cs_regs_t next_regs;
  cs_clock_pkg::cs_bus_t  bus;
  cs_clock_pkg::cs_bus_t  next_bus;
  cs_clock_pkg::cs_boot_t boot;
  cs_clock_pkg::cs_boot_t next_boot;
  logic        strap;
  logic        next_strap;
  logic        strap_caught;
  logic        next_strap_caught;
  logic        sysref;
  logic        next_sysref;
  logic        rtc;
  logic        next_rtc;
  logic        pin;
  logic        next_pin;
  logic        oe;
  logic        next_oe;
  logic [7:0]  div_cnt;
  logic [7:0]  next_div_cnt;
  logic        div_clk;
  logic        next_div_clk;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        ready;
  logic        next_ready;
  logic        boot_go;
  logic        wr_hit;
  logic [11:0] cap;
  logic [11:0] wr_mult;
  logic [15:0] divs;
  logic        tap_pll;

  //////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped words read as zero

  function automatic logic [31:0] rd_mux(input logic [29:0] a,
                                         input cs_clock_pkg::cs_regs_t r,
                                         input logic s,
                                         input cs_clock_pkg::cs_boot_t b);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == 30'(`CS_IDX_SRC))
      d[`CS_SRC_MSB:`CS_SRC_LSB] = r.src;
    else if (a == 30'(`CS_IDX_ST3))
      d[`CS_OFF_BIT] = r.off;
    else if (a == 30'(`CS_IDX_BOOT))
    begin
      d[`CS_REF_MSB:`CS_REF_LSB]   = r.ref_sel;
      d[`CS_BYP_BIT]               = r.bypass;
      d[`CS_MULT_MSB:`CS_MULT_LSB] = r.mult;
    end
    else if (a == 30'(`CS_IDX_STAT))
      d = {8'h00, r.i2c_div, r.spi_div, 5'h00, b, s};
    else if (a == 30'(`CS_IDX_SLEW))
      d[15:0] = r.slew;
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    next_regs         = regs;
    next_bus          = bus;
    next_boot         = boot;
    next_rdata        = rdata;
    next_ready        = 1'b1;
    boot_go           = 1'b0;
    // Strap is caught once after reset release and never resampled
    next_strap        = strap_caught ? strap : clock_select_strap;
    next_strap_caught = 1'b1;

    // Bus: writes are zero-wait, reads take one wait state so they see prior writes
    wr_hit  = bus.wr;
    wr_mult = hwdata[`CS_MULT_MSB:`CS_MULT_LSB];
    cap     = mult_max(strap, hwdata[`CS_REF_MSB:`CS_REF_LSB]);
    if (bus.rd)
    begin
      next_rdata  = rd_mux(bus.addr, regs, strap, boot);
      next_bus.rd = 1'b0;
    end
    if (wr_hit)
    begin
      next_bus.wr = 1'b0;
      if (bus.addr == 30'(`CS_IDX_SRC))
        next_regs.src = cs_clock_pkg::cs_src_t'(hwdata[`CS_SRC_MSB:`CS_SRC_LSB]);
      else if (bus.addr == 30'(`CS_IDX_ST3))
        next_regs.off = hwdata[`CS_OFF_BIT];
      else if (bus.addr == 30'(`CS_IDX_BOOT))
      begin
        next_regs.ref_sel = hwdata[`CS_REF_MSB:`CS_REF_LSB];
        next_regs.bypass  = hwdata[`CS_BYP_BIT];
        next_regs.mult    = (wr_mult > cap) ? cap : wr_mult;
        boot_go           = hwdata[`CS_GO_BIT];
      end
      else if (bus.addr == 30'(`CS_IDX_SLEW))
        next_regs.slew = hwdata[15:0];
    end
    if (hsel && htrans[1] && hready)
    begin
      next_bus.addr = haddr[31:2];
      next_bus.wr   = hwrite;
      next_bus.rd   = !hwrite;
      next_ready    = hwrite;
    end

    // Divisors follow the latest reference select; the caught strap fixes the source
    divs = boot_divs(strap, regs.ref_sel);

    // Boot sequence: hardware settings win over a same-cycle software write
    unique case (boot)
      cs_clock_pkg::CS_BOOT_WAIT:
        if (boot_go)
          next_boot = cs_clock_pkg::CS_BOOT_LOAD;
      cs_clock_pkg::CS_BOOT_LOAD:
      begin
        next_regs.off     = 1'b1;
        next_regs.bypass  = 1'b1;
        next_regs.spi_div = divs[7:0];
        next_regs.i2c_div = divs[15:8];
        next_boot         = cs_clock_pkg::CS_BOOT_DONE;
      end
      cs_clock_pkg::CS_BOOT_DONE:
        next_boot = boot;
      default:
        next_boot = cs_clock_pkg::CS_BOOT_WAIT;
    endcase

    // Reference routing; the external input is never looked at while select is low
    next_sysref = strap ? external_reference_clock_input : osc_32k_clock;
    next_rtc    = osc_32k_clock;

    // Slow debug tap from a toggle divider
    next_div_clk = div_clk;
    next_div_cnt = div_cnt + 8'h01;
    if (div_cnt == `CS_DBG_DIV - 8'h01)
    begin
      next_div_cnt = 8'h00;
      next_div_clk = !div_clk;
    end

    tap_pll = regs.bypass ? sysref : pll_output_clock;
    unique case (regs.src)
      cs_clock_pkg::CS_SRC_SYSREF: next_pin = sysref;
      cs_clock_pkg::CS_SRC_PLL:    next_pin = tap_pll;
      cs_clock_pkg::CS_SRC_RTC:    next_pin = rtc;
      cs_clock_pkg::CS_SRC_DIV:    next_pin = div_clk;
    endcase
    next_oe = !next_regs.off;
    if (!next_oe)
      next_pin = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regs         <= '{src: cs_clock_pkg::CS_SRC_SYSREF, off: 1'b0, ref_sel: 2'h0,
                        bypass: 1'b0, mult: `CS_MULT_RST, slew: `CS_SLEW_RST,
                        spi_div: 8'h00, i2c_div: 8'h00};
      bus          <= '{rd: 1'b0, wr: 1'b0, addr: 30'h0000_0000};
      boot         <= cs_clock_pkg::CS_BOOT_WAIT;
      strap        <= 1'b0;
      strap_caught <= 1'b0;
      sysref       <= 1'b0;
      rtc          <= 1'b0;
      pin          <= 1'b0;
      oe           <= 1'b1;
      div_cnt      <= 8'h00;
      div_clk      <= 1'b0;
      rdata        <= 32'h0000_0000;
      ready        <= 1'b1;
    end
    else
    begin
      regs         <= next_regs;
      bus          <= next_bus;
      boot         <= next_boot;
      strap        <= next_strap;
      strap_caught <= next_strap_caught;
      sysref       <= next_sysref;
      rtc          <= next_rtc;
      pin          <= next_pin;
      oe           <= next_oe;
      div_cnt      <= next_div_cnt;
      div_clk      <= next_div_clk;
      rdata        <= next_rdata;
      ready        <= next_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken from a flip-flop except hresp, which is tied low

  // Every transfer answers OKAY; unmapped words are simply ignored
  // Transfer size is not decoded: only whole aligned words are supported
  assign hrdata                 = rdata;
  assign hreadyout              = ready;
  assign hresp                  = 1'b0;
  assign sys_ref_clock          = sysref;
  assign rtc_clock              = rtc;
  assign debug_clock_output_pin = pin;
  assign debug_clock_output_oe  = oe;
  assign debug_clock_slew       = regs.slew;
  assign pll_bypass             = regs.bypass;
  assign pll_mult               = regs.mult;
  assign spi_clock_divider      = regs.spi_div;
  assign i2c_clock_divider      = regs.i2c_div;

endmodule // cs_clock_select

//--- cs_board_model.sv
// Board straps and external clock sources around the clock select block
`timescale 1ns/1ps
module cs_board_model (
  input  wire logic strap_high,
  output logic      clock_select_strap,
  output logic      osc_32k_clock,
  output logic      external_reference_clock_input,
  output logic      pll_output_clock
);
  logic ext_run;
  // Periods are shortened so that each clock toggles within a short run
  // Half periods never land on a rising bench clock edge, so sampling is race free
  initial
  begin
    osc_32k_clock = 1'b0;
    ext_run = 1'b0;
    pll_output_clock = 1'b0;
    fork
      forever #170 osc_32k_clock = ~osc_32k_clock;
      forever #40 ext_run = ~ext_run;
      forever #6 pll_output_clock = ~pll_output_clock;
    join
  end
  // Tied strap, changed by the bench only while reset is held
  assign clock_select_strap = strap_high;
  // Input grounded unless the strap selects it
  assign external_reference_clock_input = strap_high & ext_run;
endmodule // cs_board_model

//--- cs_clock_select_properties.sv
// Concurrent checks on the ports of the clock select block
`timescale 1ns/1ps
`include "cs_clock_map.svh"
module cs_clock_select_properties (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        clock_select_strap,
  input wire logic        osc_32k_clock,
  input wire logic        external_reference_clock_input,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sys_ref_clock,
  input wire logic        rtc_clock,
  input wire logic        debug_clock_output_pin,
  input wire logic        debug_clock_output_oe,
  input wire logic [15:0] debug_clock_slew,
  input wire logic [11:0] pll_mult
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = hsel & htrans[1] & hready;
  property p_ref_low;
    !clock_select_strap && $past(reset_n) |-> sys_ref_clock == $past(osc_32k_clock);
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("sys ref not oscillator");
  // Strap is captured after release, so allow its settling edges
  property p_ref_high;
    clock_select_strap && $past(reset_n, 3)
      |-> sys_ref_clock == $past(external_reference_clock_input);
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("sys ref not external");
  property p_rtc;
    $past(reset_n) |-> rtc_clock == $past(osc_32k_clock);
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc clock not oscillator");
  property p_hiz;
    !debug_clock_output_oe |-> !debug_clock_output_pin;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven while off");
  property p_off;
    (take && hwrite && haddr[31:2] == 30'(`CS_IDX_ST3)) ##1 hwdata[`CS_OFF_BIT]
      |=> !debug_clock_output_oe;
  endproperty
  a_off: assert property (p_off) else $error("pin not disabled");
  property p_rst;
    $rose(reset_n) |-> debug_clock_output_oe && pll_mult == `CS_MULT_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("pin not enabled after reset");
  property p_slew;
    (take && hwrite && haddr[31:2] == 30'(`CS_IDX_SLEW)) ##1 1'b1
      |=> debug_clock_slew == $past(hwdata[15:0]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew not written");
  property p_mult;
    pll_mult <= 12'(`CS_PLL_MAX_HZ / `CS_OSC_HZ);
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier above limit");
  // The slowest external reference allows the largest external multiplier
  property p_mult_ext;
    clock_select_strap |-> pll_mult <= 12'(`CS_PLL_MAX_HZ / `CS_REF0_HZ);
  endproperty
  a_mult_ext: assert property (p_mult_ext) else $error("external multiplier high");
  property p_read;
    take && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout && !hresp;
  endproperty
  a_read: assert property (p_read) else $error("read wait state wrong");
endmodule // cs_clock_select_properties

bind cs_clock_select cs_clock_select_properties u_props (
  .mclk                           (mclk),
  .reset_n                        (reset_n),
  .clock_select_strap             (clock_select_strap),
  .osc_32k_clock                  (osc_32k_clock),
  .external_reference_clock_input (external_reference_clock_input),
  .hsel                           (hsel),
  .haddr                          (haddr),
  .htrans                         (htrans),
  .hwrite                         (hwrite),
  .hwdata                         (hwdata),
  .hready                         (hready),
  .hreadyout                      (hreadyout),
  .hresp                          (hresp),
  .sys_ref_clock                  (sys_ref_clock),
  .rtc_clock                      (rtc_clock),
  .debug_clock_output_pin         (debug_clock_output_pin),
  .debug_clock_output_oe          (debug_clock_output_oe),
  .debug_clock_slew               (debug_clock_slew),
  .pll_mult                       (pll_mult)
);

//--- tb_clock_source_select_and_debug_out.sv
// Self-checking bench for the clock select block
`timescale 1ns/1ps
`include "cs_clock_map.svh"
module tb_clock_source_select_and_debug_out;
  localparam logic [31:0] A_SRC  = 32'(`CS_IDX_SRC) << 2;
  localparam logic [31:0] A_ST3  = 32'(`CS_IDX_ST3) << 2;
  localparam logic [31:0] A_BOOT = 32'(`CS_IDX_BOOT) << 2;
  localparam logic [31:0] A_STAT = 32'(`CS_IDX_STAT) << 2;
  localparam logic [31:0] A_SLEW = 32'(`CS_IDX_SLEW) << 2;
  logic        mclk, reset_n, strap_high, hsel, hwrite, hready, hreadyout, hresp;
  logic        clock_select_strap, osc_32k_clock, external_reference_clock_input;
  logic        pll_output_clock, sys_ref_clock, rtc_clock, pll_bypass;
  logic        debug_clock_output_pin, debug_clock_output_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] debug_clock_slew;
  logic [11:0] pll_mult;
  logic [7:0]  spi_clock_divider, i2c_clock_divider;
  int          err_total, cmp_count, t;
  cs_clock_select dut (
    .mclk                           (mclk),
    .reset_n                        (reset_n),
    .clock_select_strap             (clock_select_strap),
    .osc_32k_clock                  (osc_32k_clock),
    .external_reference_clock_input (external_reference_clock_input),
    .pll_output_clock               (pll_output_clock),
    .hsel                           (hsel),
    .haddr                          (haddr),
    .htrans                         (htrans),
    .hwrite                         (hwrite),
    .hsize                          (hsize),
    .hwdata                         (hwdata),
    .hready                         (hready),
    .hrdata                         (hrdata),
    .hreadyout                      (hreadyout),
    .hresp                          (hresp),
    .sys_ref_clock                  (sys_ref_clock),
    .rtc_clock                      (rtc_clock),
    .debug_clock_output_pin         (debug_clock_output_pin),
    .debug_clock_output_oe          (debug_clock_output_oe),
    .debug_clock_slew               (debug_clock_slew),
    .pll_bypass                     (pll_bypass),
    .pll_mult                       (pll_mult),
    .spi_clock_divider              (spi_clock_divider),
    .i2c_clock_divider              (i2c_clock_divider)
  );
  cs_board_model u_board (
    .strap_high                     (strap_high),
    .clock_select_strap             (clock_select_strap),
    .osc_32k_clock                  (osc_32k_clock),
    .external_reference_clock_input (external_reference_clock_input),
    .pll_output_clock               (pll_output_clock)
  );
  assign hready = hreadyout;
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic do_reset(input logic s);
    reset_n    <= 1'b0;
    strap_high <= s;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  // Counts level changes of the debug pin over a fixed span
  task automatic toggles();
    logic p;
    t = 0;
    p = debug_clock_output_pin;
    repeat (40)
    begin
      @(posedge mclk);
      if (debug_clock_output_pin !== p)
        t++;
      p = debug_clock_output_pin;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_n, strap_high, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    do_reset(1'b0);
    check(32'(debug_clock_output_oe), 32'h1);
    rdchk(A_SLEW, 32'h0);
    rdchk(A_BOOT, 32'h10);
    rdchk(A_ST3, 32'h0);
    $display("test reset done");
    bus(1'b1, A_BOOT, 32'h1);
    repeat (5) @(posedge mclk);
    check(32'(debug_clock_output_oe), 32'h0);
    check(32'(pll_bypass), 32'h1);
    rdchk(A_STAT, 32'h00010106);
    check(32'({i2c_clock_divider, spi_clock_divider}), 32'h0101);
    $display("test boot low done");
    bus(1'b1, A_BOOT, 32'hfff8);
    repeat (2) @(posedge mclk);
    check(32'(pll_mult), 32'he4e);
    bus(1'b1, A_SLEW, 32'h1234abcd);
    repeat (2) @(posedge mclk);
    check(32'(debug_clock_slew), 32'habcd);
    rdchk(A_SLEW, 32'habcd);
    bus(1'b1, 32'h7100, 32'h5);
    rdchk(32'h7100, 32'h0);
    $display("test registers done");
    bus(1'b1, A_ST3, 32'h0);
    repeat (2) @(posedge mclk);
    check(32'(debug_clock_output_oe), 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, A_SRC, 32'(s));
      toggles();
      check(32'(t != 0), 32'h1);
    end
    // Bypass off: the PLL tap toggles far faster than the oscillator
    bus(1'b1, A_BOOT, 32'h0);
    bus(1'b1, A_SRC, 32'h1);
    toggles();
    check(32'(pll_bypass), 32'h0);
    check(32'(t > 6), 32'h1);
    bus(1'b1, A_ST3, 32'h1);
    repeat (2) @(posedge mclk);
    check(32'(debug_clock_output_oe), 32'h0);
    check(32'(debug_clock_output_pin), 32'h0);
    $display("test debug pin done");
    do_reset(1'b1);
    check(32'(debug_clock_output_oe), 32'h1);
    rdchk(A_SLEW, 32'h0);
    bus(1'b1, A_BOOT, 32'h3);
    repeat (5) @(posedge mclk);
    rdchk(A_STAT, 32'h001e1807);
    check(32'({i2c_clock_divider, spi_clock_divider}), 32'h1e18);
    bus(1'b1, A_BOOT, 32'hfff2);
    repeat (2) @(posedge mclk);
    check(32'(pll_mult), 32'ha);
    $display("test strap high done");
    complete_run();
  end
endmodule // tb_clock_source_select_and_debug_out
